// file: design/circ_cfg.svh
// constants of the interrupt, exception and reset control block
`ifndef CIRC_CFG_SVH
`define CIRC_CFG_SVH
`define CIRC_FLAGS_RST 16'h0002
`define CIRC_STATUS_RST 16'hFFF0
`define CIRC_IP_RST 16'hFFF0
`define CIRC_CS_RST 16'hF000
`define CIRC_SEG_RST 16'h0000
`define CIRC_IDT_BASE_RST 24'h000000
`define CIRC_IDT_LIMIT_RST 16'h03FF
`define CIRC_IF_BIT 9
`define CIRC_STEP_BIT 8
`define CIRC_PROT_BIT 0
`define CIRC_MON_BIT 1
`define CIRC_EMUL_BIT 2
`define CIRC_TSW_BIT 3
`define CIRC_VEC_STEP 8'h01
`define CIRC_VEC_NMI 8'h02
`define CIRC_VEC_COP 8'h07
`define CIRC_VEC_LIMIT 8'h08
`define CIRC_VEC_OVR 8'h09
`define CIRC_VEC_SEG 8'h0D
`define CIRC_INIT_CYCLES 4'h8
`define CIRC_ADDR_HI 4'hF
`endif

// file: design/circ_pkg.sv
// types of the interrupt, exception and reset control block
`default_nettype none
package circ_pkg;
	typedef enum logic [3:0] {
		ST_INIT = 4'b0000,
		ST_RUN = 4'b0001,
		ST_HALT = 4'b0010,
		ST_ACK = 4'b0011,
		ST_CHECK = 4'b0100,
		ST_PUSH = 4'b0101,
		ST_VEC = 4'b0110,
		ST_SHUT = 4'b0111,
		ST_CHAIN = 4'b1000
	} circ_state_t;
	typedef enum logic [2:0] {
		SRC_NONE = 3'b000,
		SRC_EXC = 3'b001,
		SRC_STEP = 3'b010,
		SRC_NMI = 3'b011,
		SRC_OVR = 3'b100,
		SRC_MASKABLE_IRQ_IN = 3'b101,
		SRC_SWI = 3'b110
	} circ_src_t;
endpackage : circ_pkg
`default_nettype wire

// file: design/circ_arb_if.sv
// request and grant lines between control and priority arbiter
`default_nettype none
interface circ_arb_if;
	import circ_pkg::*;
	logic exc_v;
	logic step_v;
	logic nmi_v;
	logic ovr_v;
	logic maskable_irq_in_v;
	logic swi_v;
	logic [7:0] exc_vec;
	logic [7:0] swi_vec;
	circ_src_t src;
	logic [7:0] vec;
	modport req (output exc_v, step_v, nmi_v, ovr_v, maskable_irq_in_v, swi_v,
		exc_vec, swi_vec, input src, vec);
	modport arb (input exc_v, step_v, nmi_v, ovr_v, maskable_irq_in_v, swi_v,
		exc_vec, swi_vec, output src, vec);
endinterface : circ_arb_if
`default_nettype wire

// file: design/circ_arb.sv
// fixed priority arbiter for simultaneous interrupt requests
`include "circ_cfg.svh"
`default_nettype none
module circ_arb (
	circ_arb_if.arb a
);
	import circ_pkg::*;

	always_comb begin
		a.src = SRC_NONE;
		a.vec = 8'h00;
		if (a.exc_v) begin
			a.src = SRC_EXC;
			a.vec = a.exc_vec;
		end else if (a.step_v) begin
			a.src = SRC_STEP;
			a.vec = `CIRC_VEC_STEP;
		end else if (a.nmi_v) begin
			a.src = SRC_NMI;
			a.vec = `CIRC_VEC_NMI;
		end else if (a.ovr_v) begin
			a.src = SRC_OVR;
			a.vec = `CIRC_VEC_OVR;
		end else if (a.maskable_irq_in_v) begin
			a.src = SRC_MASKABLE_IRQ_IN;
		end else if (a.swi_v) begin
			a.src = SRC_SWI;
			a.vec = a.swi_vec;
		end
	end
endmodule : circ_arb
`default_nettype wire

// file: design/circ_top.sv
// interrupt, exception, reset and halt control top level
`include "circ_cfg.svh"
`default_nettype none
module circ_top (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic instr_done_i,
	input wire logic [15:0] next_cs_i,
	input wire logic [15:0] next_ip_i,
	input wire logic [15:0] instr_ip_i,
	input wire logic fault_i,
	input wire logic [7:0] fault_vec_i,
	input wire logic swint_i,
	input wire logic [7:0] swint_vec_i,
	input wire logic coproc_escape_instr_i,
	input wire logic wait_instr_i,
	input wire logic halt_instruction_i,
	input wire logic interrupt_return_i,
	input wire logic word_ffff_i,
	input wire logic exec_past_end_i,
	input wire logic escape_overrun_i,
	input wire logic flags_wr_i,
	input wire logic [15:0] flags_wdata_i,
	input wire logic load_status_word_instr_i,
	input wire logic [15:0] status_wdata_i,
	input wire logic seg_wr_i,
	input wire logic [1:0] seg_sel_i,
	input wire logic [15:0] seg_wdata_i,
	input wire logic idt_wr_i,
	input wire logic [23:0] idt_base_i,
	input wire logic [15:0] idt_limit_i,
	input wire logic io_i,
	input wire logic io_imm_i,
	input wire logic [7:0] io_port8_i,
	input wire logic [15:0] port_number_register_i,
	input wire logic nmi_i,
	input wire logic maskable_irq_in_i,
	input wire logic inta_valid_i,
	input wire logic [7:0] inta_vec_i,
	input wire logic vec_valid_i,
	input wire logic [15:0] vec_cs_i,
	input wire logic [15:0] vec_ip_i,
	output logic run_o,
	output logic halted_o,
	output logic shutdown_o,
	output logic [23:0] fetch_addr_o,
	output logic [15:0] flags_o,
	output logic [15:0] machine_status_word_o,
	output logic [15:0] cs_o,
	output logic [15:0] ip_o,
	output logic [15:0] ds_o,
	output logic [15:0] es_o,
	output logic [15:0] ss_o,
	output logic [15:0] io_addr_o,
	output logic inta_o,
	output logic push_o,
	output logic [15:0] push_data_o,
	output logic vec_rd_o,
	output logic [23:0] vec_addr_o,
	output logic redirect_o
);
	import circ_pkg::*;

	// ****************************************
	// state
	// ****************************************
	circ_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [15:0] flags_q, flags_d;
	logic [15:0] status_q, status_d;
	logic [15:0] cs_q, cs_d;
	logic [15:0] ip_q, ip_d;
	logic [15:0] seg_q [0:2];
	logic [15:0] seg_d [0:2];
	logic [15:0] ret_cs_q, ret_cs_d;
	logic [15:0] ret_ip_q, ret_ip_d;
	logic [15:0] fix_cs_q, fix_cs_d;
	logic [15:0] fix_ip_q, fix_ip_d;
	logic [7:0] vec_q, vec_d;
	logic [23:0] idt_base_q, idt_base_d;
	logic [15:0] idt_limit_q, idt_limit_d;
	logic [23:0] vaddr_q, vaddr_d;
	logic [15:0] io_addr_q, io_addr_d;
	logic [15:0] pdata_q, pdata_d;
	logic push_q, push_d;
	logic redir_q, redir_d;
	logic hi_q, hi_d;
	logic nmi_prev_q, nmi_prev_d;
	logic nmi_pend_q, nmi_pend_d;
	logic nmi_busy_q, nmi_busy_d;
	logic boundary, evalable, busy_eff, cop_trap, seg_fault, over_limit;
	logic [15:0] flags_eff;
	logic [19:0] lin_addr;

	circ_arb_if arb_bus ();
	circ_arb u_arb (
		.a(arb_bus)
	);

	// ****************************************
	// request gathering
	// ****************************************
	always_comb begin
		boundary = (st_q == ST_RUN) && instr_done_i;
		evalable = boundary || (st_q == ST_HALT) || (st_q == ST_CHAIN);
		flags_eff = flags_wr_i ? flags_wdata_i : flags_q;
		busy_eff = nmi_busy_q && !interrupt_return_i;
		cop_trap = (coproc_escape_instr_i &&
			(status_q[`CIRC_EMUL_BIT] || status_q[`CIRC_TSW_BIT])) ||
			(wait_instr_i && status_q[`CIRC_MON_BIT] &&
			status_q[`CIRC_TSW_BIT]);
		seg_fault = word_ffff_i || exec_past_end_i;
		arb_bus.exc_v = boundary && (fault_i || cop_trap || seg_fault);
		arb_bus.exc_vec = fault_i ? fault_vec_i :
			(cop_trap ? `CIRC_VEC_COP : `CIRC_VEC_SEG);
		arb_bus.step_v = boundary && flags_q[`CIRC_STEP_BIT];
		arb_bus.nmi_v = evalable && nmi_pend_q && !busy_eff;
		arb_bus.ovr_v = boundary && escape_overrun_i && !busy_eff;
		arb_bus.maskable_irq_in_v = evalable && maskable_irq_in_i &&
			flags_eff[`CIRC_IF_BIT] && !busy_eff;
		arb_bus.swi_v = boundary && swint_i;
		arb_bus.swi_vec = swint_vec_i;
		over_limit = {6'h00, vec_q, 2'b11} > idt_limit_q;
		lin_addr = {cs_q, 4'h0} + {4'h0, ip_q};
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		flags_d = flags_wr_i ? flags_wdata_i : flags_q;
		status_d = status_q;
		cs_d = cs_q;
		ip_d = ip_q;
		for (int i = 0; i < 3; i++) begin
			seg_d[i] = seg_q[i];
		end
		ret_cs_d = ret_cs_q;
		ret_ip_d = ret_ip_q;
		fix_cs_d = fix_cs_q;
		fix_ip_d = fix_ip_q;
		vec_d = vec_q;
		idt_base_d = idt_wr_i ? idt_base_i : idt_base_q;
		idt_limit_d = idt_wr_i ? idt_limit_i : idt_limit_q;
		vaddr_d = vaddr_q;
		io_addr_d = io_addr_q;
		pdata_d = pdata_q;
		push_d = 1'b0;
		redir_d = 1'b0;
		hi_d = hi_q;
		nmi_prev_d = nmi_i;
		nmi_busy_d = nmi_busy_q && !interrupt_return_i;
		// latch wins over a clear in the same cycle
		nmi_pend_d = nmi_pend_q;
		if (arb_bus.src == SRC_NMI) begin
			nmi_pend_d = 1'b0;
			nmi_busy_d = 1'b1;
		end
		if (nmi_i && !nmi_prev_q) begin
			nmi_pend_d = 1'b1;
		end
		if (io_i) begin
			io_addr_d = io_imm_i ? {8'h00, io_port8_i} :
				port_number_register_i;
		end
		if (load_status_word_instr_i) begin
			status_d = {status_q[15:4], status_wdata_i[3:1],
				status_wdata_i[`CIRC_PROT_BIT] || status_q[`CIRC_PROT_BIT]};
		end
		if (seg_wr_i && seg_sel_i != 2'b11) begin
			seg_d[seg_sel_i] = seg_wdata_i;
		end
		if (boundary) begin
			cs_d = next_cs_i;
			ip_d = next_ip_i;
			if (next_cs_i != cs_q) begin
				hi_d = 1'b0;
			end
		end
		if (arb_bus.src != SRC_NONE) begin
			vec_d = arb_bus.vec;
			if (arb_bus.src == SRC_EXC) begin
				ret_cs_d = cs_q;
				ret_ip_d = instr_ip_i;
			end else if (boundary) begin
				ret_cs_d = next_cs_i;
				ret_ip_d = next_ip_i;
			end else begin
				ret_cs_d = cs_q;
				ret_ip_d = ip_q;
			end
			// restart point if the vector misses the table limit
			fix_cs_d = ret_cs_d;
			fix_ip_d = ret_ip_d;
			if (arb_bus.src == SRC_SWI) begin
				fix_cs_d = cs_q;
				fix_ip_d = instr_ip_i;
			end
			// maskable request vector comes from the acknowledge read, others from the arbiter
			st_d = (arb_bus.src == SRC_MASKABLE_IRQ_IN) ? ST_ACK : ST_CHECK;
		end
		case (st_q)
			ST_INIT: begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == `CIRC_INIT_CYCLES - 4'h1) begin
					cnt_d = 4'h0;
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (boundary && arb_bus.src == SRC_NONE &&
					halt_instruction_i) begin
					st_d = ST_HALT;
				end
			end
			ST_HALT: begin
			end
			ST_ACK: begin
				if (inta_valid_i) begin
					vec_d = inta_vec_i;
					st_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (over_limit) begin
					if (vec_q == `CIRC_VEC_LIMIT || vec_q == `CIRC_VEC_SEG) begin
						st_d = ST_SHUT;
					end else begin
						vec_d = `CIRC_VEC_LIMIT;
						ret_cs_d = fix_cs_q;
						ret_ip_d = fix_ip_q;
					end
				end else begin
					vaddr_d = idt_base_q + {14'h0000, vec_q, 2'b00};
					cnt_d = 4'h0;
					st_d = ST_PUSH;
				end
			end
			ST_PUSH: begin
				push_d = 1'b1;
				cnt_d = cnt_q + 4'h1;
				case (cnt_q)
					4'h0: begin
						pdata_d = flags_q;
						flags_d[`CIRC_IF_BIT] = 1'b0;
						flags_d[`CIRC_STEP_BIT] = 1'b0;
					end
					4'h1: begin
						pdata_d = ret_cs_q;
					end
					default: begin
						pdata_d = ret_ip_q;
						cnt_d = 4'h0;
						st_d = ST_VEC;
					end
				endcase
			end
			ST_VEC: begin
				if (vec_valid_i) begin
					cs_d = vec_cs_i;
					ip_d = vec_ip_i;
					hi_d = 1'b0;
					redir_d = 1'b1;
					st_d = ST_CHAIN;
				end
			end
			ST_CHAIN: begin
				if (arb_bus.src == SRC_NONE) begin
					st_d = ST_RUN;
				end
			end
			ST_SHUT: begin
			end
			default: begin
				st_d = ST_INIT;
			end
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			st_q <= ST_INIT;
			cnt_q <= 4'h0;
			flags_q <= `CIRC_FLAGS_RST;
			status_q <= `CIRC_STATUS_RST;
			cs_q <= `CIRC_CS_RST;
			ip_q <= `CIRC_IP_RST;
			for (int i = 0; i < 3; i++) begin
				seg_q[i] <= `CIRC_SEG_RST;
			end
			ret_cs_q <= 16'h0000;
			ret_ip_q <= 16'h0000;
			fix_cs_q <= 16'h0000;
			fix_ip_q <= 16'h0000;
			vec_q <= 8'h00;
			idt_base_q <= `CIRC_IDT_BASE_RST;
			idt_limit_q <= `CIRC_IDT_LIMIT_RST;
			vaddr_q <= 24'h000000;
			io_addr_q <= 16'h0000;
			pdata_q <= 16'h0000;
			push_q <= 1'b0;
			redir_q <= 1'b0;
			hi_q <= 1'b1;
			nmi_prev_q <= 1'b0;
			nmi_pend_q <= 1'b0;
			nmi_busy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			flags_q <= flags_d;
			status_q <= status_d;
			cs_q <= cs_d;
			ip_q <= ip_d;
			for (int i = 0; i < 3; i++) begin
				seg_q[i] <= seg_d[i];
			end
			ret_cs_q <= ret_cs_d;
			ret_ip_q <= ret_ip_d;
			fix_cs_q <= fix_cs_d;
			fix_ip_q <= fix_ip_d;
			vec_q <= vec_d;
			idt_base_q <= idt_base_d;
			idt_limit_q <= idt_limit_d;
			vaddr_q <= vaddr_d;
			io_addr_q <= io_addr_d;
			pdata_q <= pdata_d;
			push_q <= push_d;
			redir_q <= redir_d;
			hi_q <= hi_d;
			nmi_prev_q <= nmi_prev_d;
			nmi_pend_q <= nmi_pend_d;
			nmi_busy_q <= nmi_busy_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign run_o = (st_q == ST_RUN);
	assign halted_o = (st_q == ST_HALT);
	assign shutdown_o = (st_q == ST_SHUT);
	assign fetch_addr_o = {hi_q ? `CIRC_ADDR_HI : 4'h0, lin_addr};
	assign flags_o = flags_q;
	assign machine_status_word_o = status_q;
	assign cs_o = cs_q;
	assign ip_o = ip_q;
	assign ds_o = seg_q[0];
	assign es_o = seg_q[1];
	assign ss_o = seg_q[2];
	assign io_addr_o = io_addr_q;
	assign inta_o = (st_q == ST_ACK);
	assign push_o = push_q;
	assign push_data_o = pdata_q;
	assign vec_rd_o = (st_q == ST_VEC);
	assign vec_addr_o = vaddr_q;
	assign redirect_o = redir_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_io_upper_zero: assert property (
		io_i && io_imm_i |=> io_addr_o == {8'h00, $past(io_port8_i)})
		else $error("short port address not zero extended");
	chk_push_three: assert property (
		st_q == ST_PUSH && cnt_q == 4'h0 |=> push_o [*3] ##1 !push_o)
		else $error("entry did not push three words");
	chk_exc_return: assert property (
		arb_bus.src == SRC_EXC |=> ret_ip_q == $past(instr_ip_i))
		else $error("exception return address wrong");
	chk_nmi_vector: assert property (
		arb_bus.src == SRC_NMI |=> vec_q == 8'h02 && st_q == ST_CHECK)
		else $error("non-maskable entry wrong vector or acknowledged");
	chk_if_gate: assert property (
		arb_bus.src == SRC_MASKABLE_IRQ_IN |-> flags_eff[`CIRC_IF_BIT])
		else $error("maskable request taken while disabled");
	chk_if_clear: assert property (
		st_q == ST_PUSH && cnt_q == 4'h0 |=> !flags_q[`CIRC_IF_BIT] &&
		push_data_o == $past(flags_q))
		else $error("enable not cleared after flag save");
	chk_nmi_block: assert property (
		nmi_busy_q && !interrupt_return_i |-> arb_bus.src != SRC_NMI &&
		arb_bus.src != SRC_MASKABLE_IRQ_IN && arb_bus.src != SRC_OVR)
		else $error("request accepted during non-maskable service");
	chk_prot_sticky: assert property (
		status_q[`CIRC_PROT_BIT] |=> status_q[`CIRC_PROT_BIT])
		else $error("protection enable cleared");
	chk_reset_load: assert property (
		$past(sys_rst_i) |-> flags_q == 16'h0002 && status_q == 16'hFFF0 &&
		cs_q == 16'hF000 && ip_q == 16'hFFF0 && fetch_addr_o == 24'hFFFFF0)
		else $error("reset values wrong");
	chk_halt_hold: assert property (
		st_q == ST_HALT && !nmi_pend_q && !(maskable_irq_in_i &&
		flags_eff[`CIRC_IF_BIT]) |=> st_q == ST_HALT)
		else $error("left halt without a wake event");
	chk_cop_trap: assert property (
		boundary && coproc_escape_instr_i && status_q[`CIRC_EMUL_BIT] &&
		!fault_i |-> arb_bus.src == SRC_EXC && arb_bus.vec == 8'h07)
		else $error("escape did not trap with emulate set");
endmodule : circ_top
`default_nettype wire

// file: testbench/circ_partner.sv
// model of the interrupt controller and the vector table memory
`default_nettype none
module circ_partner #(
	parameter logic [7:0] IRQ_VEC = 8'h40
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic inta_req_i,
	input wire logic vec_req_i,
	input wire logic [23:0] vec_addr_i,
	output logic inta_valid_o,
	output logic [7:0] inta_vec_o,
	output logic vec_valid_o,
	output logic [15:0] vec_cs_o,
	output logic [15:0] vec_ip_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_q;
	logic slow_q;
	logic ack_q;
	logic [15:0] junk_q;
	// answers alternate between prompt and slow
	always @(posedge ref_clk_i) begin
		junk_q <= junk_q * 16'h0005 + 16'h3B1D;
		if (sys_rst_i) begin
			wait_q <= 4'h0;
			slow_q <= 1'b0;
			ack_q <= 1'b0;
			junk_q <= 16'h5A5A;
		end else if (ack_q) begin
			ack_q <= 1'b0;
			wait_q <= 4'h0;
			slow_q <= ~slow_q;
		end else if (inta_req_i || vec_req_i) begin
			ack_q <= (wait_q == (slow_q ? 4'h5 : 4'h0));
			wait_q <= wait_q + 4'h1;
		end
	end
	// data lines carry a changing pattern outside an answer
	assign inta_valid_o = ack_q & inta_req_i;
	assign inta_vec_o = inta_valid_o ? IRQ_VEC : junk_q[7:0];
	assign vec_valid_o = ack_q & vec_req_i;
	assign vec_cs_o = vec_valid_o ? 16'hC000 : junk_q;
	assign vec_ip_o = vec_valid_o ? vec_addr_i[15:0] : ~junk_q;
endmodule : circ_partner
`default_nettype wire

// file: testbench/cpu_interrupt_reset_control_test.sv
// self-checking bench of the interrupt, exception and reset control block
`default_nettype none
module cpu_interrupt_reset_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i, sys_rst_i, instr_done_i, flags_wr_i, seg_wr_i, idt_wr_i;
	logic fault_i, swint_i, word_ffff_i, exec_past_end_i, escape_overrun_i;
	logic coproc_escape_instr_i, wait_instr_i, halt_instruction_i;
	logic interrupt_return_i, load_status_word_instr_i, io_i, io_imm_i;
	logic nmi_i, maskable_irq_in_i, inta_valid_i, vec_valid_i;
	logic [1:0] seg_sel_i;
	logic [7:0] fault_vec_i, swint_vec_i, io_port8_i, inta_vec_i, fv;
	logic [15:0] next_cs_i, next_ip_i, instr_ip_i, flags_wdata_i;
	logic [15:0] status_wdata_i;
	logic [15:0] seg_wdata_i, idt_limit_i, port_number_register_i;
	logic [15:0] vec_cs_i, vec_ip_i, flags_o, machine_status_word_o, cs_o;
	logic [15:0] ip_o, ds_o, es_o, ss_o, io_addr_o, push_data_o;
	logic [23:0] idt_base_i, fetch_addr_o, vec_addr_o;
	logic run_o, halted_o, shutdown_o, inta_o, push_o, vec_rd_o, redirect_o;
	logic [8:0] qual;
	logic [15:0] exp_q[$];
	logic [15:0] cur_flags, cur_cs, nip, iip, exp_w;
	int err_total, checks_done, seed;
	assign {fault_i, swint_i, word_ffff_i, exec_past_end_i, escape_overrun_i,
		coproc_escape_instr_i, wait_instr_i, halt_instruction_i,
		interrupt_return_i} = qual;
	circ_top DUT (.*);
	circ_partner PARTNER (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.inta_req_i(inta_o),
		.vec_req_i(vec_rd_o),
		.vec_addr_i(vec_addr_o),
		.inta_valid_o(inta_valid_i),
		.inta_vec_o(inta_vec_i),
		.vec_valid_o(vec_valid_i),
		.vec_cs_o(vec_cs_i),
		.vec_ip_o(vec_ip_i)
	);
	task automatic chk(input logic [23:0] got, input logic [23:0] e);
		checks_done++;
		if (got !== e) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask : chk
	task automatic close_out;
		if (err_total == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic tick;
		@(posedge ref_clk_i);
	endtask : tick
	task automatic wt(input logic halt_instruction);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while ((halt_instruction ? halted_o : run_o) !== 1'b1 && n < 400);
		if (n >= 400) begin
			chk(24'h0, 24'h1);
			close_out();
		end
	endtask : wt
	task automatic qent(input logic [15:0] f, input logic [15:0] c,
		input logic [15:0] r, input logic [7:0] hv);
		exp_q.push_back(f);
		exp_q.push_back(c);
		exp_q.push_back(r);
		exp_q.push_back({6'h00, hv, 2'h0});
	endtask : qent
	task automatic bnd(input int k, input logic [7:0] v, input logic ex,
		input logic [7:0] hv, input logic rti, input logic [7:0] cv);
		nip = 16'($random(seed));
		iip = nip - 16'h0003;
		if (ex)
			qent(cur_flags, cur_cs, rti ? iip : nip, hv);
		if (cv != 8'hFF)
			qent(cur_flags & 16'hFCFF, 16'hC000, {6'h00, hv, 2'h0}, cv);
		wt(1'b0);
		tick();
		instr_done_i <= 1'b1;
		next_ip_i <= nip;
		instr_ip_i <= iip;
		next_cs_i <= cur_cs;
		fault_vec_i <= v;
		swint_vec_i <= v;
		qual <= 9'h100 >> k;
		flags_wr_i <= (k == 8);
		flags_wdata_i <= cur_flags;
		tick();
		instr_done_i <= 1'b0;
		qual <= '0;
		flags_wr_i <= 1'b0;
		wt(k == 7);
		if (ex) begin
			cur_flags = cur_flags & 16'hFCFF;
			cur_cs = 16'hC000;
			chk(flags_o, cur_flags);
		end
	endtask : bnd
	task automatic fw(input logic [15:0] v);
		tick();
		flags_wr_i <= 1'b1;
		flags_wdata_i <= v;
		tick();
		flags_wr_i <= 1'b0;
		cur_flags = v;
	endtask : fw
	task automatic ld(input logic [15:0] v, input logic [15:0] e);
		tick();
		load_status_word_instr_i <= 1'b1;
		status_wdata_i <= v;
		tick();
		load_status_word_instr_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(machine_status_word_o, e);
	endtask : ld
	task automatic lim(input logic [15:0] v);
		tick();
		idt_wr_i <= 1'b1;
		idt_limit_i <= v;
		tick();
		idt_wr_i <= 1'b0;
	endtask : lim
	// pushed words and handler addresses against the noted queue
	always @(posedge ref_clk_i) begin
		if (push_o === 1'b1 || redirect_o === 1'b1) begin
			exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
			chk(push_o ? push_data_o : ip_o, exp_w);
			if (redirect_o)
				chk(cs_o, 16'hC000);
		end
	end
	always @(posedge ref_clk_i) begin
		if (inta_o === 1'b1)
			maskable_irq_in_i <= 1'b0;
	end
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		seed = 71;
		sys_rst_i = 1'b1;
		qual = '0;
		{instr_done_i, flags_wr_i, seg_wr_i, idt_wr_i, io_i, io_imm_i, nmi_i,
			maskable_irq_in_i, load_status_word_instr_i, seg_sel_i} = '0;
		{fault_vec_i, swint_vec_i, io_port8_i, next_cs_i, next_ip_i} = '0;
		{instr_ip_i, flags_wdata_i, status_wdata_i, seg_wdata_i} = '0;
		{port_number_register_i, idt_base_i} = '0;
		idt_limit_i = 16'h03FF;
		repeat (12) tick();
		sys_rst_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(flags_o, 16'h0002);
		chk(machine_status_word_o, 16'hFFF0);
		chk(ip_o, 16'hFFF0);
		chk(cs_o, 16'hF000);
		chk(ds_o | es_o | ss_o, 16'h0000);
		chk(fetch_addr_o, 24'hFFFFF0);
		chk(run_o, 1'b0);
		cur_flags = 16'h0002;
		cur_cs = 16'hF000;
		repeat (34) tick();
		wt(1'b0);
		for (int i = 0; i < 4; i++) begin
			tick();
			io_i <= 1'b1;
			io_imm_i <= i[0];
			io_port8_i <= 8'($random(seed));
			port_number_register_i <= 16'($random(seed));
			seg_wr_i <= 1'b1;
			seg_sel_i <= 2'(i);
			seg_wdata_i <= 16'($random(seed));
			tick();
			io_i <= 1'b0;
			seg_wr_i <= 1'b0;
			@(negedge ref_clk_i);
			iip = io_imm_i ? {8'h00, io_port8_i} : port_number_register_i;
			chk(io_addr_o, iip);
			if (i < 3)
				chk(i == 0 ? ds_o : (i == 1 ? es_o : ss_o), seg_wdata_i);
		end
		fw(16'h0202);
		fv = 8'($random(seed));
		bnd(0, fv, 1'b1, fv, 1'b1, 8'hFF);
		bnd(2, 8'h00, 1'b1, 8'h0D, 1'b1, 8'hFF);
		bnd(3, 8'h00, 1'b1, 8'h0D, 1'b1, 8'hFF);
		bnd(4, 8'h00, 1'b1, 8'h09, 1'b0, 8'hFF);
		bnd(1, 8'h80, 1'b1, 8'h80, 1'b0, 8'hFF);
		lim(16'h003F);
		bnd(1, 8'h20, 1'b1, 8'h08, 1'b1, 8'hFF);
		lim(16'h03FF);
		fw(16'h0302);
		nmi_i <= 1'b1;
		maskable_irq_in_i <= 1'b1;
		repeat (2) tick();
		bnd(9, 8'h00, 1'b1, 8'h01, 1'b0, 8'h02);
		fw(16'h0202);
		nmi_i <= 1'b0;
		bnd(9, 8'h00, 1'b0, 8'h00, 1'b0, 8'hFF);
		tick();
		nmi_i <= 1'b1;
		repeat (2) tick();
		bnd(9, 8'h00, 1'b0, 8'h00, 1'b0, 8'hFF);
		cur_flags = 16'h0202;
		bnd(8, 8'h00, 1'b1, 8'h02, 1'b0, 8'hFF);
		tick();
		nmi_i <= 1'b0;
		cur_flags = 16'h0002;
		bnd(8, 8'h00, 1'b0, 8'h00, 1'b0, 8'hFF);
		bnd(7, 8'h00, 1'b0, 8'h00, 1'b0, 8'hFF);
		repeat (4) @(negedge ref_clk_i);
		chk({halted_o, run_o}, 2'h2);
		qent(cur_flags, cur_cs, nip, 8'h02);
		tick();
		nmi_i <= 1'b1;
		wt(1'b0);
		cur_flags = 16'h0202;
		bnd(8, 8'h00, 1'b1, 8'h40, 1'b0, 8'hFF);
		ld(16'h000A, 16'hFFFA);
		bnd(6, 8'h00, 1'b1, 8'h07, 1'b1, 8'hFF);
		ld(16'h0004, 16'hFFF4);
		bnd(6, 8'h00, 1'b0, 8'h00, 1'b0, 8'hFF);
		bnd(5, 8'h00, 1'b1, 8'h07, 1'b1, 8'hFF);
		ld(16'h0001, 16'hFFF1);
		ld(16'h0000, 16'hFFF1);
		lim(16'h0000);
		tick();
		instr_done_i <= 1'b1;
		swint_vec_i <= 8'h20;
		qual <= 9'h080;
		tick();
		instr_done_i <= 1'b0;
		qual <= '0;
		repeat (4) @(negedge ref_clk_i);
		chk({shutdown_o, run_o}, 2'h2);
		tick();
		sys_rst_i <= 1'b1;
		nmi_i <= 1'b0;
		repeat (2) tick();
		sys_rst_i <= 1'b0;
		@(negedge ref_clk_i);
		chk({shutdown_o, run_o}, 2'h0);
		chk(machine_status_word_o, 16'hFFF0);
		wt(1'b0);
		chk(fetch_addr_o, 24'hFFFFF0);
		repeat (4) tick();
		chk(24'(exp_q.size()), 24'h0);
		close_out();
	end
endmodule : cpu_interrupt_reset_control_test
`default_nettype wire
